// ==== logic/rusp_setting_port.sv ====
// module: setting access port of the remote update block
// Notes on behaviour
// RL1 - a sampled read request raises busy until the read completes
// RL2 - selector changes during a read are ignored
// RL3 - user logic starts a new read only after busy falls
// RL4 - unconnected request, selector and value inputs default to zero
// RL5 - a write request stores the value into the selected setting
// RL6 - the write value is captured on the edge where busy rises
// RL7 - value bus is 12 bits; narrow settings keep only low bits
// RL8 - write request is sampled on the rising clock edge
// RL9 - user logic holds write request high for exactly one cycle
// RL10 - a sampled write request raises busy until the write completes; the code raises busy for it only while active_image_kind_in is high
// RL11 - selector and value are ignored during a write
// RL12 - user logic issues the next write only after busy falls
// RL13 - writes only take effect while the factory image is active
// RL14 - selector is a 3-bit code choosing the target setting
// RL15 - everything runs on the rising edge of one clock
// RL16 - asynchronous reset initialises the block even while busy
// RL17 - read value bus is valid only after a read and busy falling
// RL18 - reload trigger is ignored while busy
// RL19 - user logic never asserts read and write together
module rusp_setting_port
	import rusp_pkg::*;
#(
	parameter int unsigned ACCESS_CYCLES = ACCESS_CYC
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_b_in,
	// access requests
	input  wire logic             setting_read_request_in  = 1'b0,
	input  wire logic             setting_write_request_in = 1'b0,
	input  wire logic [SEL_W-1:0] setting_select_in        = '0,
	input  wire logic [VAL_W-1:0] write_value_bus_in       = '0,
	// configuration state and reload
	input  wire logic             active_image_kind_in,
	input  wire logic             reload_trigger_in,
	// answers
	output logic                  busy_out,
	output logic [VAL_W-1:0]      read_value_bus_out,
	output logic                  reload_start_out
);

	// ****************************************
	// request and state registers
	// ****************************************
	rusp_req_t        req;
	rusp_state_t      state_r, state_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [SEL_W-1:0] sel_r, sel_nxt;
	logic [VAL_W-1:0] val_r, val_nxt;
	logic [VAL_W-1:0] rdata_r, rdata_nxt;
	logic             busy_r, busy_nxt;
	logic             reload_r, reload_nxt;
	logic [VAL_W-1:0] setting_r [NUM_SETTING];
	logic             commit;

	// unconnected request, selector and value inputs fall to their zero defaults above  [RL4]
	assign req = '{read_req: setting_read_request_in, write_req: setting_write_request_in,
		select: setting_select_in, value: write_value_bus_in};

	// ****************************************
	// access sequencer
	// ****************************************
	always_comb begin
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		sel_nxt    = sel_r;
		val_nxt    = val_r;
		rdata_nxt  = rdata_r;
		busy_nxt   = busy_r;
		reload_nxt = 1'b0;
		commit     = 1'b0;
		unique case (state_r)
			RUSP_IDLE: begin
				// a reload is only honoured while idle  [RL18]
				reload_nxt = reload_trigger_in;
				if (req.read_req) begin // [RL1] [RL15]
					state_nxt = RUSP_READ;
					sel_nxt   = req.select; // [RL14]
					cnt_nxt   = CNT_W'(ACCESS_CYCLES);
					busy_nxt  = 1'b1;
				end else if (req.write_req && active_image_kind_in) begin // [RL8] [RL10] [RL13]
					state_nxt = RUSP_WRITE;
					sel_nxt   = req.select;
					val_nxt   = req.value; // [RL6]
					cnt_nxt   = CNT_W'(ACCESS_CYCLES);
					busy_nxt  = 1'b1;
				end
			end
			RUSP_READ: begin
				// selector is not looked at here  [RL2]
				cnt_nxt = cnt_r - CNT_ONE;
				if (cnt_r == CNT_ONE) begin
					state_nxt = RUSP_IDLE;
					busy_nxt  = 1'b0;
					rdata_nxt = setting_r[sel_r]; // [RL17]
				end
			end
			RUSP_WRITE: begin
				// selector and value held from the accepting edge  [RL11]
				cnt_nxt = cnt_r - CNT_ONE;
				if (cnt_r == CNT_ONE) begin
					state_nxt = RUSP_IDLE;
					busy_nxt  = 1'b0;
					commit    = 1'b1;
				end
			end
			default: begin
				state_nxt = RUSP_IDLE;
				busy_nxt  = 1'b0;
				cnt_nxt   = CNT_ZERO;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin // [RL16]
			state_r  <= RUSP_IDLE;
			cnt_r    <= CNT_ZERO;
			sel_r    <= '0;
			val_r    <= SETTING_RST;
			rdata_r  <= SETTING_RST;
			busy_r   <= 1'b0;
			reload_r <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			sel_r    <= sel_nxt;
			val_r    <= val_nxt;
			rdata_r  <= rdata_nxt;
			busy_r   <= busy_nxt;
			reload_r <= reload_nxt;
		end
	end

	// ****************************************
	// setting store
	// ****************************************
	for (genvar i = 0; i < NUM_SETTING; i++) begin : g_setting
		logic [VAL_W-1:0] mask;
		logic [VAL_W-1:0] set_nxt;
		assign mask = VAL_W'((13'h001 << FIELD_W[i]) - 13'h001);
		always_comb begin
			set_nxt = setting_r[i];
			if (commit && (sel_r == SEL_W'(i))) begin
				set_nxt = val_r & mask; // [RL5] [RL7]
			end
		end
		always_ff @(posedge clk_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				setting_r[i] <= SETTING_RST;
			end else begin
				setting_r[i] <= set_nxt;
			end
		end
	end

	assign busy_out           = busy_r;
	assign read_value_bus_out = rdata_r;
	assign reload_start_out   = reload_r;

endmodule

// ==== logic/rusp_pkg.sv ====
// package: constants and types for the remote update setting port
package rusp_pkg;
	localparam int unsigned SEL_W       = 3;
	localparam int unsigned VAL_W       = 12;
	localparam int unsigned NUM_SETTING = 8;
	// cycles an access stays busy after the accepting edge (plain default)
	localparam int unsigned ACCESS_CYC  = 4;
	localparam int unsigned CNT_W       = 4;
	localparam logic [VAL_W-1:0] SETTING_RST = 12'h000;
	localparam logic [CNT_W-1:0] CNT_ZERO    = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE     = 4'h1;
	// width of each setting's valid field, low bits used
	localparam int unsigned FIELD_W [NUM_SETTING] = '{5, 12, 1, 12, 12, 12, 12, 12};

	typedef enum logic [1:0] {
		RUSP_IDLE  = 2'b00,
		RUSP_READ  = 2'b01,
		RUSP_WRITE = 2'b10
	} rusp_state_t;

	typedef struct packed {
		logic             read_req;
		logic             write_req;
		logic [SEL_W-1:0] select;
		logic [VAL_W-1:0] value;
	} rusp_req_t;
endpackage

// ==== testbench/rusp_monitor.sv ====
// assertions and covers on the setting port
module rusp_monitor #(parameter int unsigned ACCESS_CYCLES = 4) (
	// clock and reset
	input wire logic        clk_in,
	input wire logic        rst_b_in,
	// requests seen by the port
	input wire logic        setting_read_request_in,
	input wire logic        setting_write_request_in,
	input wire logic        active_image_kind_in,
	input wire logic        reload_trigger_in,
	// answers of the port
	input wire logic        busy_out,
	input wire logic        reload_start_out,
	input wire logic [11:0] read_value_bus_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	wire rd = !busy_out && setting_read_request_in;
	wire wr = !busy_out && setting_write_request_in && active_image_kind_in;
	wire rl = !busy_out && reload_trigger_in;
	rd_busy_a: assert property (rd |=> busy_out[*4] ##1 !busy_out) else $error("rd busy");
	wr_busy_a: assert property (wr |=> busy_out[*4] ##1 !busy_out) else $error("wr busy");
	busy_cause_a: assert property (!rd && !wr && !busy_out |=> !busy_out) else $error("cause");
	busy_len_a: assert property ($fell(busy_out) |-> $past(busy_out, ACCESS_CYCLES) && !$past(busy_out, ACCESS_CYCLES + 1)) else $error("len");
	rval_hold_a: assert property ($changed(read_value_bus_out) |-> $fell(busy_out)) else $error("rval");
	reload_busy_a: assert property (reload_start_out |-> $past(rl)) else $error("rl busy");
	reload_go_a: assert property (rl && !rd && !wr |=> reload_start_out) else $error("rl go");
	reload_one_a: assert property (reload_start_out |=> !reload_start_out) else $error("pulse");
	cover property (rd);
	cover property (wr);
	cover property (rl);
endmodule
bind rusp_setting_port rusp_monitor #(.ACCESS_CYCLES(ACCESS_CYCLES)) rusp_monitor_i (.*);

// ==== testbench/rusp_user_model.sv ====
// user logic model issuing setting reads and writes
module rusp_user_model
	import rusp_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic busy_in,
	output rusp_req_t req_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial req_out = '0;
	task automatic access(input logic wr, input logic [SEL_W-1:0] sel, input logic [VAL_W-1:0] val);
		req_out <= '{~wr, wr, sel, val};
		@(posedge clk_in);
		req_out <= '{1'h0, 1'h0, ~sel, ~val};
		@(negedge clk_in);
		while (busy_in === 1'h1) @(negedge clk_in);
		@(posedge clk_in);
	endtask
endmodule

// ==== testbench/rusp_setting_port_test.sv ====
// self-checking bench for the setting port
module rusp_setting_port_test;
	import rusp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'h0, rst_b = 1'h0, kind = 1'h1, reload = 1'h0, busy, start;
	logic [VAL_W-1:0] rval;
	rusp_req_t req;
	int fails = 0, compares = 0, cyc = 0;
	always #25 clk_in = ~clk_in;
	rusp_setting_port rusp_setting_port_i (.clk_in(clk_in), .rst_b_in(rst_b),
		.setting_read_request_in(req.read_req), .setting_write_request_in(req.write_req),
		.setting_select_in(req.select), .write_value_bus_in(req.value), .active_image_kind_in(kind),
		.reload_trigger_in(reload), .busy_out(busy), .read_value_bus_out(rval), .reload_start_out(start));
	rusp_user_model rusp_user_model_i (.clk_in(clk_in), .busy_in(busy), .req_out(req));
	task automatic check(input string what, input logic [VAL_W-1:0] exp, got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic final_report;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 1000) begin
			fails++;
			final_report();
		end
	end
	// every setting written then read back, narrow ones masked
	task automatic t_settings;
		for (int i = 0; i < NUM_SETTING; i++) begin
			rusp_user_model_i.access(1'h1, SEL_W'(i), 12'hfff - 12'(i));
			rusp_user_model_i.access(1'h0, SEL_W'(i), 12'h000);
			check("setting", (12'hfff - 12'(i)) & (12'hfff >> (VAL_W - FIELD_W[i])), rval);
		end
	endtask
	// write refused in application image, reload taken while idle
	task automatic t_app_write;
		kind <= 1'h0;
		reload <= 1'h1;
		@(posedge clk_in);
		reload <= 1'h0;
		@(negedge clk_in);
		check("reload start", 12'h001, {11'h000, start});
		@(posedge clk_in);
		rusp_user_model_i.access(1'h1, 3'h3, 12'h123);
		kind <= 1'h1;
		rusp_user_model_i.access(1'h0, 3'h3, 12'h000);
		check("app write", 12'hffc, rval);
	endtask
	// reload pulse during a read is dropped, read still returns setting 0
	task automatic t_reload_busy;
		fork
			rusp_user_model_i.access(1'h0, 3'h0, 12'h000);
			begin
				@(posedge clk_in);
				reload <= 1'h1;
				@(posedge clk_in);
				reload <= 1'h0;
				@(negedge clk_in);
				check("reload while busy", 12'h000, {11'h000, start});
			end
		join
		check("read after reload", 12'hfff >> (VAL_W - FIELD_W[0]), rval);
	endtask
	// reset pulled in the middle of a write clears busy, data and settings
	task automatic t_reset_mid;
		fork
			rusp_user_model_i.access(1'h1, 3'h1, 12'h5a5);
			begin
				repeat (2) @(posedge clk_in);
				rst_b <= 1'h0;
				@(negedge clk_in);
				check("busy in reset", 12'h000, {11'h000, busy});
				check("rval in reset", SETTING_RST, rval);
				@(posedge clk_in);
				rst_b <= 1'h1;
			end
		join
		rusp_user_model_i.access(1'h0, 3'h1, 12'h000);
		check("setting after reset", SETTING_RST, rval);
	endtask
	initial begin
		repeat (3) @(posedge clk_in);
		rst_b <= 1'h1;
		@(posedge clk_in);
		t_settings();
		t_app_write();
		t_reload_busy();
		t_reset_mid();
		final_report();
	end
endmodule
